/* File: hdl/sqtc_defines.svh */
`ifndef SQTC_DEFINES_SVH
`define SQTC_DEFINES_SVH

// Host command codes
`define SQTC_CMD_TC_IN        8'hf0
`define SQTC_CMD_TC_OUT       8'hf8
`define SQTC_CMD_RESET        8'hff
`define SQTC_CMD_ADDR_FREE    8'h09
`define SQTC_CMD_ADDR_ON      8'h89
`define SQTC_CMD_BRAKE        8'h8c

// Subcode Q frame layout
`define SQTC_FRAME_BITS       80
`define SQTC_IDX_W            7
`define SQTC_ADR_LSB          4
`define SQTC_ADR_W            4
`define SQTC_ADR_MATCH        4'h1

// Reset values
`define SQTC_RST_ADDR_FREE    1'b0
`define SQTC_RST_COUNT        8'h08

// Timing
`define SQTC_CLK_PERIOD_NS    20
`define SQTC_FLAG_TIMEOUT_NS  11200000
`define SQTC_FLAG_TIMEOUT_CYC (`SQTC_FLAG_TIMEOUT_NS / `SQTC_CLK_PERIOD_NS)
`define SQTC_TIMER_W          20

// Block buffer
`define SQTC_FIFO_DEPTH       16

`endif

/* File: hdl/sqtc_pkg.sv */
`include "sqtc_defines.svh"

package sqtc_pkg;

	typedef struct packed {
		logic                             crc_ok;
		logic [`SQTC_FRAME_BITS-1:0]      bits;
	} sqtc_block_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} sqtc_cmd_t;

	typedef enum logic [1:0] {
		TC_IDLE,
		TC_WAIT_COUNT,
		TC_ARMED,
		TC_RUN
	} sqtc_tc_state_t;

endpackage : sqtc_pkg

/* File: hdl/sqtc_fifo.sv */
`timescale 1ns/1ps

module sqtc_fifo #(
	parameter int WIDTH = 81,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign out_valid_o = (count_reg != '0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			in_ready_o <= 1'b0;
		end else if (ce_i) begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= in_data_i;
				wr_ptr_reg          <= AW'(wr_ptr_reg + 1'b1);
			end
			if (pop)
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			count_reg  <= count_next;
			in_ready_o <= (count_next != (AW+1)'(DEPTH));
		end
	end

endmodule : sqtc_fifo

/* File: hdl/sqtc_top.sv */
// Behaviour
// - Track check in or out code makes the next byte the track count.
// - Count is 8 to 254; the check passes one track more than given.
// - Falling edge of the read/write strobe starts the armed check.
// - Tracking-off output stays high while a check runs.
// - A check command turns the ready flag into the check monitor.
// - Flag rises at the count halfway point and falls at the end.
// - Check repeats with the same count until the reset code arrives.
// - Ready flag rises only for a CRC-good block with address field one.
// - Address-free code drops both conditions; address code restores them.
// - Serial output gives one bit per shift clock, least significant first.
// - Block updates are frozen once the host starts shifting.
// - Strobe high pulse releases updates and drops the ready flag.
// - Ready flag drops by itself 11.2 ms after rising.
// - Serial output is driven only while select is low.
// - Ready flag also monitors internal braking while no track check is in progress.
`timescale 1ns/1ps
`include "sqtc_defines.svh"

module sqtc_top
	import sqtc_pkg::*;
#(
	parameter int TIMEOUT_CYC = `SQTC_FLAG_TIMEOUT_CYC
) (
	// Clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Host commands and strobe
	input  wire sqtc_cmd_t   cmd_i,
	input  wire logic        readwrite_ctrl_strobe_i,
	// Decoded subcode Q blocks
	input  wire logic        blk_valid_i,
	output logic             blk_ready_o,
	input  wire sqtc_block_t blk_i,
	// Servo side
	input  wire logic        track_cross_i,
	input  wire logic        brake_active_i,
	output logic             tracking_off_out_o,
	output logic             tc_outward_o,
	// Readout link
	input  wire logic        subq_shift_clock_i,
	input  wire logic        subq_cs_n_i,
	output logic             subq_serial_out_o,
	output logic             subq_serial_oe_n_o,
	// Flag
	output logic             qdata_ready_flag_o
);

	localparam logic [`SQTC_TIMER_W-1:0] TIMEOUT_LAST = `SQTC_TIMER_W'(TIMEOUT_CYC - 1);

	// Pin synchronisers
	logic [1:0] rwc_sync_reg;
	logic       rwc_prev_reg;
	logic [1:0] cross_sync_reg;
	logic       cross_prev_reg;
	logic [1:0] brake_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] start_sync_reg;
	logic       start_prev_reg;

	logic rwc_fall;
	logic rwc_rise;
	logic cross_rise;
	logic link_start;

	assign rwc_fall   = rwc_prev_reg && !rwc_sync_reg[1];
	assign rwc_rise   = !rwc_prev_reg && rwc_sync_reg[1];
	assign cross_rise = !cross_prev_reg && cross_sync_reg[1];
	assign link_start = !start_prev_reg && start_sync_reg[1];

	// Link domain state
	logic [`SQTC_IDX_W-1:0] bit_idx_reg;
	logic                   link_started_reg;

	// Track check state
	sqtc_tc_state_t tc_state_reg;
	sqtc_tc_state_t tc_state_next;
	logic [7:0]     tc_count_reg;
	logic [7:0]     cross_cnt_reg;
	logic           tc_flag_reg;
	logic           addr_free_reg;
	logic           tc_dir_reg;

	// Readout state
	sqtc_block_t               fifo_out;
	logic                      fifo_valid;
	logic                      fifo_pop;
	logic [`SQTC_FRAME_BITS-1:0] frame_reg;
	logic                      q_flag_reg;
	logic                      lock_reg;
	logic [`SQTC_TIMER_W-1:0]  timer_reg;
	logic                      qualified;
	logic                      timeout_hit;
	logic                      flag_next;

	function automatic logic [7:0] half_point(input logic [7:0] n);
		half_point = 8'((9'(n) + 9'h001) >> 1);
	endfunction : half_point

	sqtc_fifo #(
		.WIDTH ($bits(sqtc_block_t)),
		.DEPTH (`SQTC_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (blk_valid_i),
		.in_ready_o  (blk_ready_o),
		.in_data_i   (blk_i),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out)
	);

	// Command decode
	logic cmd_tc;
	logic cmd_reset;
	logic cmd_afree;
	logic cmd_aon;

	assign cmd_tc    = cmd_i.valid && ((cmd_i.code == `SQTC_CMD_TC_IN) || (cmd_i.code == `SQTC_CMD_TC_OUT));
	assign cmd_reset = cmd_i.valid && (cmd_i.code == `SQTC_CMD_RESET);
	assign cmd_afree = cmd_i.valid && (cmd_i.code == `SQTC_CMD_ADDR_FREE);
	assign cmd_aon   = cmd_i.valid && (cmd_i.code == `SQTC_CMD_ADDR_ON);

	// Track check sequencing
	always_comb begin
		tc_state_next = tc_state_reg;
		case (tc_state_reg)
			TC_IDLE:       if (cmd_tc) tc_state_next = TC_WAIT_COUNT;
			TC_WAIT_COUNT: if (cmd_i.valid) tc_state_next = TC_ARMED;
			TC_ARMED:      if (rwc_fall) tc_state_next = TC_RUN;
			TC_RUN:        tc_state_next = TC_RUN;
			default:       tc_state_next = TC_IDLE;
		endcase
		if (cmd_reset)
			tc_state_next = TC_IDLE;
	end

	// Readout qualification
	assign qualified   = addr_free_reg ||
		(fifo_out.crc_ok &&
		 fifo_out.bits[`SQTC_ADR_LSB +: `SQTC_ADR_W] == `SQTC_ADR_MATCH);
	assign fifo_pop    = fifo_valid && !q_flag_reg && !lock_reg;
	assign timeout_hit = q_flag_reg && (timer_reg == TIMEOUT_LAST);
	assign flag_next   = (tc_state_reg != TC_IDLE) ? tc_flag_reg :
	                     brake_sync_reg[1] ? 1'b1 :
	                     q_flag_reg;

	// Synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rwc_sync_reg   <= 2'h0;
			rwc_prev_reg   <= 1'b0;
			cross_sync_reg <= 2'h0;
			cross_prev_reg <= 1'b0;
			brake_sync_reg <= 2'h0;
			cs_sync_reg    <= 2'h3;
			start_sync_reg <= 2'h0;
			start_prev_reg <= 1'b0;
		end else if (ce_i) begin
			rwc_sync_reg   <= {rwc_sync_reg[0], readwrite_ctrl_strobe_i};
			rwc_prev_reg   <= rwc_sync_reg[1];
			cross_sync_reg <= {cross_sync_reg[0], track_cross_i};
			cross_prev_reg <= cross_sync_reg[1];
			brake_sync_reg <= {brake_sync_reg[0], brake_active_i};
			cs_sync_reg    <= {cs_sync_reg[0], subq_cs_n_i};
			start_sync_reg <= {start_sync_reg[0], link_started_reg};
			start_prev_reg <= start_sync_reg[1];
		end
	end

	// Track check counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tc_state_reg  <= TC_IDLE;
			tc_count_reg  <= `SQTC_RST_COUNT;
			cross_cnt_reg <= 8'h00;
			tc_flag_reg   <= 1'b0;
			tc_dir_reg    <= 1'b0;
			addr_free_reg <= `SQTC_RST_ADDR_FREE;
		end else if (ce_i) begin
			tc_state_reg <= tc_state_next;
			if (tc_state_reg == TC_IDLE && cmd_tc)
				tc_dir_reg <= (cmd_i.code == `SQTC_CMD_TC_OUT);
			if (tc_state_reg == TC_WAIT_COUNT && cmd_i.valid && !cmd_reset)
				tc_count_reg <= cmd_i.code;
			if (cmd_afree)
				addr_free_reg <= 1'b1;
			else if (cmd_aon)
				addr_free_reg <= 1'b0;
			if (tc_state_reg != TC_RUN) begin
				cross_cnt_reg <= 8'h00;
				tc_flag_reg   <= 1'b0;
			end else if (cross_rise) begin
				if (cross_cnt_reg == tc_count_reg) begin
					cross_cnt_reg <= 8'h00;
					tc_flag_reg   <= 1'b0;
				end else begin
					cross_cnt_reg <= 8'(cross_cnt_reg + 8'h01);
					if (8'(cross_cnt_reg + 8'h01) == half_point(tc_count_reg))
						tc_flag_reg <= 1'b1;
				end
			end
		end
	end

	// Subcode Q hold, lock and timeout
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_reg  <= '0;
			q_flag_reg <= 1'b0;
			lock_reg   <= 1'b0;
			timer_reg  <= '0;
		end else if (ce_i) begin
			if (fifo_pop) begin
				frame_reg  <= fifo_out.bits;
				q_flag_reg <= qualified;
				timer_reg  <= '0;
			end else if (rwc_rise || timeout_hit) begin
				q_flag_reg <= 1'b0;
			end else if (q_flag_reg) begin
				timer_reg <= `SQTC_TIMER_W'(timer_reg + 1'b1);
			end
			if (link_start)
				lock_reg <= 1'b1;
			else if (rwc_rise)
				lock_reg <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			qdata_ready_flag_o <= 1'b0;
			tracking_off_out_o <= 1'b0;
			tc_outward_o       <= 1'b0;
			subq_serial_oe_n_o <= 1'b1;
		end else if (ce_i) begin
			qdata_ready_flag_o <= flag_next;
			tracking_off_out_o <= (tc_state_reg == TC_RUN);
			tc_outward_o       <= tc_dir_reg;
			subq_serial_oe_n_o <= cs_sync_reg[1];
		end
	end

	// Link domain: bit pointer cleared while select is high
	always_ff @(posedge subq_shift_clock_i or posedge subq_cs_n_i) begin
		if (subq_cs_n_i) begin
			bit_idx_reg      <= '0;
			link_started_reg <= 1'b0;
		end else begin
			link_started_reg <= 1'b1;
			if (bit_idx_reg != `SQTC_IDX_W'(`SQTC_FRAME_BITS - 1))
				bit_idx_reg <= `SQTC_IDX_W'(bit_idx_reg + 1'b1);
		end
	end

	// Frame is frozen while shifting, so its bits are stable here
	always_ff @(posedge subq_shift_clock_i) begin
		subq_serial_out_o <= frame_reg[bit_idx_reg];
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_tc_load;
		ce_i && tc_state_reg == TC_WAIT_COUNT && cmd_i.valid && !cmd_reset
		|=> tc_state_reg == TC_ARMED && tc_count_reg == $past(cmd_i.code);
	endproperty
	a_tc_load: assert property (p_tc_load) else $error("count byte not taken");

	property p_tc_start;
		ce_i && tc_state_reg == TC_ARMED && rwc_fall && !cmd_reset |=> tc_state_reg == TC_RUN;
	endproperty
	a_tc_start: assert property (p_tc_start) else $error("check did not start");

	property p_tracking_off_out;
		ce_i && tc_state_reg == TC_RUN |=> tracking_off_out_o;
	endproperty
	a_tracking_off_out: assert property (p_tracking_off_out) else $error("tracking not off");

	property p_monitor;
		ce_i && tc_state_reg != TC_IDLE |=> qdata_ready_flag_o == $past(tc_flag_reg);
	endproperty
	a_monitor: assert property (p_monitor) else $error("flag not check monitor");

	property p_finish;
		ce_i && tc_state_reg == TC_RUN && cross_rise && cross_cnt_reg == tc_count_reg && !cmd_reset
		|=> !tc_flag_reg && cross_cnt_reg == 8'h00 && tc_state_reg == TC_RUN;
	endproperty
	a_finish: assert property (p_finish) else $error("check end or repeat wrong");

	property p_half;
		ce_i && tc_state_reg == TC_RUN && cross_rise && cross_cnt_reg != tc_count_reg
		&& 8'(cross_cnt_reg + 8'h01) == half_point(tc_count_reg) |=> tc_flag_reg;
	endproperty
	a_half: assert property (p_half) else $error("halfway flag missing");

	property p_reset_cmd;
		ce_i && cmd_reset |=> tc_state_reg == TC_IDLE ##1 (!tracking_off_out_o || !$past(ce_i));
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset code ignored");

	property p_qual;
		ce_i && fifo_pop && !addr_free_reg && !fifo_out.crc_ok |=> !q_flag_reg;
	endproperty
	a_qual: assert property (p_qual) else $error("flag raised for bad block");

	property p_afree;
		ce_i && cmd_afree |=> addr_free_reg;
	endproperty
	a_afree: assert property (p_afree) else $error("address free not set");

	property p_release;
		ce_i && rwc_rise && !fifo_pop && !link_start |=> !q_flag_reg && !lock_reg;
	endproperty
	a_release: assert property (p_release) else $error("release not honoured");

	property p_timeout;
		ce_i && timeout_hit && !fifo_pop |=> !q_flag_reg;
	endproperty
	a_timeout: assert property (p_timeout) else $error("flag timeout missed");

	property p_tc_begin;
		ce_i && tc_state_reg == TC_IDLE && cmd_tc |=> tc_state_reg == TC_WAIT_COUNT;
	endproperty
	a_tc_begin: assert property (p_tc_begin) else $error("check command not taken");

	property p_lock_hold;
		ce_i && lock_reg |=> frame_reg == $past(frame_reg);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("frame changed while locked");

	property p_oe;
		ce_i |=> subq_serial_oe_n_o == $past(cs_sync_reg[1]);
	endproperty
	a_oe: assert property (p_oe) else $error("output enable not following select");

	property p_brake;
		ce_i && tc_state_reg == TC_IDLE && brake_sync_reg[1] |=> qdata_ready_flag_o;
	endproperty
	a_brake: assert property (p_brake) else $error("braking monitor missing");

endmodule : sqtc_top

/* File: tb/sqtc_host_model.sv */
`timescale 1ns/1ps
`include "sqtc_defines.svh"

module sqtc_host_model (
	// Readout request from the bench
	input  wire logic                         rd_req_i,
	output logic                              rd_done_o,
	output logic [`SQTC_FRAME_BITS-1:0]       frame_o,
	// Readout link
	input  wire logic                         subq_pin_i,
	output logic                              subq_shift_clock_o,
	output logic                              subq_cs_n_o
);
	initial begin
		subq_shift_clock_o = 1'b0;
		subq_cs_n_o = 1'b1;
		rd_done_o = 1'b0;
		frame_o = '0;
	end

	// Shift clock runs at 12 ns only inside a selected frame
	always @(posedge rd_req_i) begin
		rd_done_o = 1'b0;
		subq_cs_n_o = 1'b0;
		#100;
		for (int k = 0; k < `SQTC_FRAME_BITS; k++) begin
			#6 subq_shift_clock_o = 1'b1;
			#6 subq_shift_clock_o = 1'b0;
			frame_o[k] = subq_pin_i;
		end
		#60;
		subq_cs_n_o = 1'b1;
		rd_done_o = 1'b1;
	end
endmodule : sqtc_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "sqtc_defines.svh"

module tb_top;
	import sqtc_pkg::*;
	localparam int TO = 200;
	logic        clk_i, rst_i, readwrite_ctrl_strobe_i, blk_valid_i, blk_ready_o;
	logic        track_cross_i, brake_active_i, tracking_off_out_o, tc_outward_o;
	logic        subq_shift_clock_i, subq_cs_n_i, subq_serial_out_o, subq_serial_oe_n_o;
	logic        qdata_ready_flag_o, rd_req, rd_done, ce_i;
	logic [79:0] frame;
	sqtc_cmd_t   cmd_i;
	sqtc_block_t blk_i;
	wire         sq_pin = subq_serial_oe_n_o ? 1'bz : subq_serial_out_o;
	int          n_errors, cmp_count, cycles, w, n, half;
	logic [79:0] exp_q[$];

	sqtc_top #(.TIMEOUT_CYC(TO)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_i(cmd_i),
		.readwrite_ctrl_strobe_i(readwrite_ctrl_strobe_i), .blk_valid_i(blk_valid_i),
		.blk_ready_o(blk_ready_o), .blk_i(blk_i), .track_cross_i(track_cross_i),
		.brake_active_i(brake_active_i), .tracking_off_out_o(tracking_off_out_o),
		.tc_outward_o(tc_outward_o), .subq_shift_clock_i(subq_shift_clock_i),
		.subq_cs_n_i(subq_cs_n_i), .subq_serial_out_o(subq_serial_out_o),
		.subq_serial_oe_n_o(subq_serial_oe_n_o), .qdata_ready_flag_o(qdata_ready_flag_o));

	sqtc_host_model i_host (.rd_req_i(rd_req), .rd_done_o(rd_done), .frame_o(frame), .subq_pin_i(sq_pin),
		.subq_shift_clock_o(subq_shift_clock_i), .subq_cs_n_o(subq_cs_n_i));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#2;
	endtask : cyc

	task automatic wait_flag(input logic v, input int lim);
		w = 0;
		while (qdata_ready_flag_o !== v && w < lim) begin
			cyc(1);
			w++;
		end
	endtask : wait_flag

	task automatic send(input logic [7:0] c);
		cmd_i = '{1'b1, c};
		cyc(1);
		cmd_i.valid = 1'b0;
		cyc(1);
	endtask : send

	task automatic push(input logic crc, input logic [3:0] adr, input logic q);
		logic [95:0] r;
		while (blk_ready_o !== 1'b1)
			cyc(1);
		r = {$urandom, $urandom, $urandom};
		r[7:4] = adr;
		blk_i = '{crc, r[79:0]};
		if (q)
			exp_q.push_back(r[79:0]);
		blk_valid_i = 1'b1;
		cyc(1);
		blk_valid_i = 1'b0;
	endtask : push

	task automatic strobe();
		readwrite_ctrl_strobe_i = 1'b1;
		cyc(5);
		readwrite_ctrl_strobe_i = 1'b0;
		cyc(6);
	endtask : strobe

	task automatic read_frame();
		rd_req = 1'b1;
		cyc(10);
		chk("oe_n selected", subq_serial_oe_n_o, 1'b0);
		push(1'b1, 4'h1, 1'b1);
		for (int i = 0; i < 200 && rd_done !== 1'b1; i++)
			cyc(1);
		rd_req = 1'b0;
		chk("frame", frame, exp_q.pop_front());
		cyc(5);
		chk("oe_n released", subq_serial_oe_n_o, 1'b1);
	endtask : read_frame

	initial begin
		rst_i = 1'b1;
		cmd_i = '0;
		blk_i = '0;
		{readwrite_ctrl_strobe_i, blk_valid_i, track_cross_i, brake_active_i, rd_req} = '0;
		ce_i = 1'b1;
		w = $urandom(32'h6c675a2a);
		repeat (4) @(posedge clk_i);
		#2 rst_i = 1'b0;
		cyc(2);
		chk("reset tracking_off_out", tracking_off_out_o, 1'b0);
		chk("reset oe_n", subq_serial_oe_n_o, 1'b1);
		chk("block ready", blk_ready_o, 1'b1);
		push(1'b1, 4'h1, 1'b1);
		wait_flag(1'b1, 10);
		chk("flag good block", qdata_ready_flag_o, 1'b1);
		read_frame();
		wait_flag(1'b0, TO);
		cyc(10);
		chk("update locked", qdata_ready_flag_o, 1'b0);
		readwrite_ctrl_strobe_i = 1'b1;
		wait_flag(1'b1, 10);
		chk("flag next block", qdata_ready_flag_o, 1'b1);
		readwrite_ctrl_strobe_i = 1'b0;
		cyc(3);
		readwrite_ctrl_strobe_i = 1'b1;
		wait_flag(1'b0, 8);
		chk("flag release", qdata_ready_flag_o, 1'b0);
		readwrite_ctrl_strobe_i = 1'b0;
		exp_q.delete();
		push(1'b1, 4'h1, 1'b0);
		wait_flag(1'b1, 10);
		ce_i = 1'b0;
		cyc(50);
		chk("flag frozen", qdata_ready_flag_o, 1'b1);
		ce_i = 1'b1;
		wait_flag(1'b0, TO + 20);
		chk("flag timeout", w >= TO - 5 && w <= TO + 5, 1'b1);
		for (int i = 0; i < 2; i++) begin
			push(logic'(i), 4'(i + 1), 1'b0);
			wait_flag(1'b1, 10);
			chk("flag bad block", qdata_ready_flag_o, 1'b0);
		end
		send(`SQTC_CMD_ADDR_FREE);
		push(1'b0, 4'h3, 1'b0);
		wait_flag(1'b1, 10);
		chk("flag address free", qdata_ready_flag_o, 1'b1);
		strobe();
		send(`SQTC_CMD_ADDR_ON);
		push(1'b0, 4'h1, 1'b0);
		wait_flag(1'b1, 10);
		chk("flag address on", qdata_ready_flag_o, 1'b0);
		brake_active_i = 1'b1;
		wait_flag(1'b1, 8);
		chk("flag braking", qdata_ready_flag_o, 1'b1);
		brake_active_i = 1'b0;
		wait_flag(1'b0, 8);
		for (int r = 0; r < 2; r++) begin
			n = r ? $urandom_range(254, 8) : 8;
			half = (n + 1) >> 1;
			send(r ? `SQTC_CMD_TC_IN : `SQTC_CMD_TC_OUT);
			send(8'(n));
			strobe();
			chk("tracking_off_out running", tracking_off_out_o, 1'b1);
			chk("direction", tc_outward_o, logic'(r == 0));
			chk("monitor idle", qdata_ready_flag_o, 1'b0);
			for (int rep = 0; rep < 2; rep++) begin
				for (int c = 1; c <= n + 1; c++) begin
					track_cross_i = 1'b1;
					cyc(3);
					track_cross_i = 1'b0;
					cyc(4);
					chk("monitor", qdata_ready_flag_o, logic'(c >= half && c <= n));
				end
			end
			send(`SQTC_CMD_BRAKE);
			chk("tracking_off_out after brake", tracking_off_out_o, 1'b1);
			send(`SQTC_CMD_RESET);
			cyc(3);
			chk("tracking_off_out stopped", tracking_off_out_o, 1'b0);
		end
		send(`SQTC_CMD_ADDR_FREE);
		send(`SQTC_CMD_TC_IN);
		send(8'h08);
		strobe();
		chk("tracking_off_out before reset", tracking_off_out_o, 1'b1);
		rst_i = 1'b1;
		cyc(2);
		rst_i = 1'b0;
		cyc(2);
		chk("mid reset tracking_off_out", tracking_off_out_o, 1'b0);
		chk("mid reset flag", qdata_ready_flag_o, 1'b0);
		push(1'b0, 4'h3, 1'b0);
		wait_flag(1'b1, 10);
		chk("address on after reset", qdata_ready_flag_o, 1'b0);
		summarize();
	end
endmodule : tb_top
